// *** logic/ckctl_top.sv ***
// Clock output stop, reset and divider control with APB registers
//
// Functional notes
// - stop select picks which of three banks run
// - reset input low tristates outputs, resets logic
// - reset low tristates outputs whatever stop select says
// - stop select acts only while outputs enabled
// - external feedback reset opens loop, oscillator slowest
// - internal feedback reset leaves lock undisturbed
// - range and bank selects set frequency ratios
// - range low divides by two, high four
// - feedback low internal sixteen, high external input
// - reference low crystal, high single-ended input
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "ckctl_map.svh"
module ckctl_top
  import ckctl_pkg::*;
#(
  parameter int ADDR_W = 8  // APB address width
) (
  input wire logic ref_clk_i,                       // Block clock, 125 MHz
  input wire logic rst_n_i,                         // Async reset, active low
  input wire logic output_enable_master_reset_i,    // Low: outputs off, logic reset
  input wire logic crystal_reference_i,             // Crystal oscillator reference
  input wire logic single_ended_reference_input_i,  // Single-ended reference
  input wire logic external_feedback_input_i,       // External feedback clock
  input wire logic psel_i,                          // APB select
  input wire logic penable_i,                       // APB enable
  input wire logic pwrite_i,                        // APB direction
  input wire logic [ADDR_W-1:0] paddr_i,            // APB address
  input wire logic [31:0] pwdata_i,                 // APB write data
  input wire logic [3:0] pstrb_i,                   // APB byte strobes
  output logic [31:0] prdata_o,                     // APB read data
  output logic pready_o,                            // APB ready
  output logic pslverr_o,                           // APB error
  output logic [1:0] bank_a_outputs_o,              // Bank A clocks
  output logic [1:0] bank_a_outputs_oe_o,           // Bank A drive enables
  output logic [1:0] bank_b_outputs_o,              // Bank B clocks
  output logic [1:0] bank_b_outputs_oe_o,           // Bank B drive enables
  output logic [1:0] bank_c_outputs_o,              // Bank C clocks
  output logic [1:0] bank_c_outputs_oe_o            // Bank C drive enables
);

  ckctl_bank_if bif_a ();
  ckctl_bank_if bif_b ();
  ckctl_bank_if bif_c ();

  ckctl_ctrl_t ctrl_ff, nxt_ctrl;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata, stat_word;
  logic access, hit_ctrl, hit_stat;

  // APB decode
  assign access = psel_i & penable_i;
  assign hit_ctrl = (paddr_i == ADDR_W'(`CKCTL_CTRL_OFS));
  assign hit_stat = (paddr_i == ADDR_W'(`CKCTL_STAT_OFS));

  // APB slave: one wait state, write lands on the completing edge
  always_comb begin
    nxt_pready = access & ~pready_ff;
    nxt_pslverr = 1'b0;
    nxt_prdata = 32'h0000_0000;
    nxt_ctrl = ctrl_ff;
    if (access & ~pready_ff) begin
      nxt_pslverr = ~(hit_ctrl | hit_stat);
      if (!pwrite_i && hit_ctrl) begin
        nxt_prdata = {24'h00_0000, ctrl_ff};
      end else if (!pwrite_i && hit_stat) begin
        nxt_prdata = stat_word;
      end
    end
    if (access & pready_ff & pwrite_i & hit_ctrl & pstrb_i[0]) begin
      nxt_ctrl = ckctl_ctrl_t'(pwdata_i[7:0]);
    end
  end

  // APB registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      ctrl_ff <= ckctl_ctrl_t'(`CKCTL_CTRL_RST_VAL);
    end else begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  // Error flop is only ever set together with ready, so it drives the pin directly
  assign pslverr_o = pslverr_ff;

  // Oscillator, feedback and lock state
  logic oe_ff, nxt_oe;
  logic [4:0] pre_cnt_ff, nxt_pre_cnt, pre_lim;
  logic [3:0] fb_cnt_ff, nxt_fb_cnt;
  logic [3:0] miss_ff, nxt_miss;
  logic lost_ff, nxt_lost;
  logic ref_prev_ff, nxt_ref_prev, fbx_prev_ff, nxt_fbx_prev;
  logic loop_open, vco_tick, ref_sel_clk, ref_rise, fb_rise, fb_ext;

  // Reference and feedback source selection
  assign ref_sel_clk = ctrl_ff.ref_sel ? single_ended_reference_input_i
                                       : crystal_reference_i;
  assign fb_ext = ctrl_ff.feedback_source_select;
  assign loop_open = ~oe_ff & fb_ext;
  assign ref_rise = ref_sel_clk & ~ref_prev_ff;

  // Oscillator tick rate: range divide, slowed to the minimum while the loop is open
  always_comb begin
    pre_lim = ctrl_ff.vco_range_select ? (`CKCTL_RANGE_DIV_HI - 5'h01)
                                       : (`CKCTL_RANGE_DIV_LO - 5'h01);
    if (loop_open) begin
      // Product worked in six bits so that eight times four does not wrap
      pre_lim = 5'(6'(`CKCTL_VCO_MIN_MUL) * 6'(ctrl_ff.vco_range_select ? `CKCTL_RANGE_DIV_HI
                                               : `CKCTL_RANGE_DIV_LO) - 6'h01);
    end
  end

  assign vco_tick = (pre_cnt_ff >= pre_lim);
  assign fb_rise = fb_ext ? (external_feedback_input_i & ~fbx_prev_ff)
                          : (vco_tick & (fb_cnt_ff == 4'hF));

  // Next values of oscillator, feedback divider and lock tracking
  always_comb begin
    nxt_oe = output_enable_master_reset_i;
    nxt_ref_prev = ref_sel_clk;
    nxt_fbx_prev = external_feedback_input_i;
    nxt_pre_cnt = vco_tick ? 5'h00 : pre_cnt_ff + 5'h01;
    nxt_fb_cnt = vco_tick ? fb_cnt_ff + 4'h1 : fb_cnt_ff;  // Divide by sixteen wraps
    nxt_miss = miss_ff;
    nxt_lost = lost_ff;
    if (fb_rise) begin
      nxt_miss = 4'h0;
    end else if (ref_rise && miss_ff != `CKCTL_LOCK_MISS_LIMIT) begin
      nxt_miss = miss_ff + 4'h1;
    end
    // Lock is lost only by a missing external feedback; held until a reset pulse or a switch to internal feedback
    if (fb_ext && oe_ff && miss_ff == `CKCTL_LOCK_MISS_LIMIT) begin
      nxt_lost = 1'b1;
    end
    if (loop_open) begin
      nxt_miss = 4'h0;
      nxt_lost = 1'b0;
    end
    if (!fb_ext) begin
      nxt_lost = 1'b0;
    end
  end

  // Oscillator and lock registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_ff <= 1'b0;
      ref_prev_ff <= 1'b0;
      fbx_prev_ff <= 1'b0;
      pre_cnt_ff <= 5'h00;
      fb_cnt_ff <= 4'h0;
      miss_ff <= 4'h0;
      lost_ff <= 1'b0;
    end else begin
      oe_ff <= nxt_oe;
      ref_prev_ff <= nxt_ref_prev;
      fbx_prev_ff <= nxt_fbx_prev;
      pre_cnt_ff <= nxt_pre_cnt;
      fb_cnt_ff <= nxt_fb_cnt;
      miss_ff <= nxt_miss;
      lost_ff <= nxt_lost;
    end
  end

  // Bank run requests from the stop select
  logic run_a, run_b, run_c;
  always_comb begin
    run_a = 1'b0;
    run_b = 1'b0;
    run_c = 1'b0;
    unique case (ctrl_ff.stop_sel)
      CKCTL_STOP_A_ONLY: begin
        run_a = 1'b1;
      end
      CKCTL_STOP_A_C: begin
        run_a = 1'b1;
        run_c = 1'b1;
      end
      CKCTL_STOP_C_ONLY: begin
        run_c = 1'b1;
      end
      CKCTL_STOP_ALL_RUN: begin
        run_a = 1'b1;
        run_b = 1'b1;
        run_c = 1'b1;
      end
    endcase
  end

  // Bank control wiring; reset low overrides every stop setting
  assign bif_a.tick = vco_tick;
  assign bif_b.tick = vco_tick;
  assign bif_c.tick = vco_tick;
  assign bif_a.div_len = ctrl_ff.div_a_sel ? `CKCTL_DIVA_1 : `CKCTL_DIVA_0;
  assign bif_b.div_len = ctrl_ff.div_b_sel ? `CKCTL_DIVB_1 : `CKCTL_DIVB_0;
  assign bif_c.div_len = ctrl_ff.div_c_sel ? `CKCTL_DIVC_1 : `CKCTL_DIVC_0;
  assign bif_a.run_req = run_a & oe_ff;
  assign bif_b.run_req = run_b & oe_ff;
  assign bif_c.run_req = run_c & oe_ff;
  assign bif_a.logic_rst = ~oe_ff;
  assign bif_b.logic_rst = ~oe_ff;
  assign bif_c.logic_rst = ~oe_ff;

  ckctl_bank u_bank_a (
    .ref_clk_i (ref_clk_i),
    .rst_n_i (rst_n_i),
    .bif (bif_a)
  );
  ckctl_bank u_bank_b (
    .ref_clk_i (ref_clk_i),
    .rst_n_i (rst_n_i),
    .bif (bif_b)
  );
  ckctl_bank u_bank_c (
    .ref_clk_i (ref_clk_i),
    .rst_n_i (rst_n_i),
    .bif (bif_c)
  );

  // Status word
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`CKCTL_STAT_RUNA_BIT] = bif_a.running;
    stat_word[`CKCTL_STAT_RUNB_BIT] = bif_b.running;
    stat_word[`CKCTL_STAT_RUNC_BIT] = bif_c.running;
    stat_word[`CKCTL_STAT_OE_BIT] = oe_ff;
    stat_word[`CKCTL_STAT_OPEN_BIT] = loop_open;
    stat_word[`CKCTL_STAT_VMIN_BIT] = loop_open;
    stat_word[`CKCTL_STAT_LOCK_BIT] = ~lost_ff & ~loop_open;
  end

  // Two pins per bank share one registered clock and enable
  assign bank_a_outputs_o = {2{bif_a.q}};
  assign bank_a_outputs_oe_o = {2{bif_a.oe}};
  assign bank_b_outputs_o = {2{bif_b.q}};
  assign bank_b_outputs_oe_o = {2{bif_b.oe}};
  assign bank_c_outputs_o = {2{bif_c.q}};
  assign bank_c_outputs_oe_o = {2{bif_c.oe}};

endmodule : ckctl_top
`default_nettype wire

// *** common/ckctl_map.svh ***
// Offsets, field positions, reset values and counts of the clock output control block
`ifndef CKCTL_MAP_SVH
`define CKCTL_MAP_SVH

// Register byte offsets on the APB bus
`define CKCTL_CTRL_OFS 8'h00
`define CKCTL_STAT_OFS 8'h04

// Control register fields
`define CKCTL_CTRL_STOP_LSB 0
`define CKCTL_CTRL_RANGE_BIT 2
`define CKCTL_CTRL_DIVA_BIT 3
`define CKCTL_CTRL_DIVB_BIT 4
`define CKCTL_CTRL_DIVC_BIT 5
`define CKCTL_CTRL_FBSEL_BIT 6
`define CKCTL_CTRL_REFSEL_BIT 7
`define CKCTL_CTRL_RST_VAL 8'h03

// Status register fields
`define CKCTL_STAT_RUNA_BIT 0
`define CKCTL_STAT_RUNB_BIT 1
`define CKCTL_STAT_RUNC_BIT 2
`define CKCTL_STAT_OE_BIT 3
`define CKCTL_STAT_OPEN_BIT 4
`define CKCTL_STAT_VMIN_BIT 5
`define CKCTL_STAT_LOCK_BIT 6

// Oscillator and divider ratios
`define CKCTL_RANGE_DIV_LO 5'h02
`define CKCTL_RANGE_DIV_HI 5'h04
`define CKCTL_VCO_MIN_MUL 5'h08
`define CKCTL_INT_FB_DIV 5'h10
`define CKCTL_DIVA_0 3'h2
`define CKCTL_DIVA_1 3'h4
`define CKCTL_DIVB_0 3'h2
`define CKCTL_DIVB_1 3'h4
`define CKCTL_DIVC_0 3'h4
`define CKCTL_DIVC_1 3'h6

// Reference edges without feedback before lock counts as lost
`define CKCTL_LOCK_MISS_LIMIT 4'h4

`endif

// *** common/ckctl_pkg.sv ***
// Types shared by the clock output control block
package ckctl_pkg;

  // Clock-stop select codes
  typedef enum logic [1:0] {
    CKCTL_STOP_A_ONLY = 2'b00,
    CKCTL_STOP_A_C = 2'b01,
    CKCTL_STOP_C_ONLY = 2'b10,
    CKCTL_STOP_ALL_RUN = 2'b11
  } ckctl_stop_t;

  // Control register layout
  typedef struct packed {
    logic ref_sel;
    logic feedback_source_select;
    logic div_c_sel;
    logic div_b_sel;
    logic div_a_sel;
    logic vco_range_select;
    ckctl_stop_t stop_sel;
  } ckctl_ctrl_t;

endpackage : ckctl_pkg

// *** common/ckctl_bank_if.sv ***
// Carrier between the control core and one output bank
`timescale 1ns/10ps
`default_nettype none
interface ckctl_bank_if;
  logic tick;
  logic [2:0] div_len;
  logic run_req;
  logic logic_rst;
  logic q;
  logic oe;
  logic running;

  modport bank (input tick, input div_len, input run_req, input logic_rst,
                output q, output oe, output running);
  modport ctrl (output tick, output div_len, output run_req, output logic_rst,
                input q, input oe, input running);
endinterface : ckctl_bank_if
`default_nettype wire

// *** logic/ckctl_bank.sv ***
// One output bank: divider, glitch-free stop gate and output drive
`timescale 1ns/10ps
`default_nettype none
module ckctl_bank
  import ckctl_pkg::*;
(
  input wire logic ref_clk_i,   // Block clock
  input wire logic rst_n_i,     // Async reset, active low
  ckctl_bank_if.bank bif        // Control side
);

  logic sync1_ff, sync2_ff, gate_ff, q_ff, oe_ff;
  logic nxt_sync1, nxt_sync2, nxt_gate, nxt_q, nxt_oe;
  logic [2:0] cnt_ff, nxt_cnt, half;

  // Next state: synchroniser, divider counter and gate
  always_comb begin
    half = {1'b0, bif.div_len[2:1]};
    nxt_sync1 = bif.run_req;
    nxt_sync2 = sync1_ff;
    nxt_cnt = cnt_ff;
    nxt_gate = gate_ff;
    if (bif.tick) begin
      if (cnt_ff >= bif.div_len - 3'h1) begin
        nxt_cnt = 3'h0;
      end else begin
        nxt_cnt = cnt_ff + 3'h1;
      end
      // Gate moves only on the tick that leaves count zero
      if (cnt_ff == 3'h0) begin
        nxt_gate = sync2_ff;
      end
    end
    nxt_q = nxt_gate & (nxt_cnt >= half);
    nxt_oe = 1'b1;
    if (bif.logic_rst) begin
      nxt_sync1 = 1'b0;
      nxt_sync2 = 1'b0;
      nxt_cnt = 3'h0;
      nxt_gate = 1'b0;
      nxt_q = 1'b0;
      nxt_oe = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      cnt_ff <= 3'h0;
      gate_ff <= 1'b0;
      q_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      cnt_ff <= nxt_cnt;
      gate_ff <= nxt_gate;
      q_ff <= nxt_q;
      oe_ff <= nxt_oe;
    end
  end

  assign bif.q = q_ff;
  assign bif.oe = oe_ff;
  assign bif.running = gate_ff;

endmodule : ckctl_bank
`default_nettype wire

// *** tb/ckctl_top_props.sv ***
// Port-level checker for the clock output control block
`timescale 1ns/10ps
`default_nettype none
module ckctl_top_props #(
  parameter int ADDR_W = 8  // Address width
) (
  input wire logic ref_clk_i,  // Clock
  input wire logic rst_n_i,  // Reset
  input wire logic output_enable_master_reset_i,  // Enable pin
  input wire logic psel_i,  // Select
  input wire logic penable_i,  // Enable
  input wire logic [ADDR_W-1:0] paddr_i,  // Address
  input wire logic pready_o,  // Ready
  input wire logic pslverr_o,  // Error
  input wire logic [1:0] bank_a_outputs_o,  // Bank A
  input wire logic [1:0] bank_a_outputs_oe_o,  // Bank A enable
  input wire logic [1:0] bank_b_outputs_o,  // Bank B
  input wire logic [1:0] bank_b_outputs_oe_o,  // Bank B enable
  input wire logic [1:0] bank_c_outputs_o,  // Bank C
  input wire logic [1:0] bank_c_outputs_oe_o  // Bank C enable
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic oemr;
  logic acc;
  logic [5:0] oes;
  logic [5:0] qs;
  // Gathered views of the pins
  assign oemr = output_enable_master_reset_i;
  assign acc = psel_i && penable_i && !pready_o;
  assign oes = {bank_a_outputs_oe_o, bank_b_outputs_oe_o, bank_c_outputs_oe_o};
  assign qs = {bank_a_outputs_o, bank_b_outputs_o, bank_c_outputs_o};
  // Enable pin reaches every drive enable two edges later
  chk_oe_drop: assert property (!oemr |-> ##2 oes == 6'h00)
    else $error("drive enables not cleared");
  chk_oe_rise: assert property ((oemr && rst_n_i) [*3] |-> oes == 6'h3F)
    else $error("drive enables not set");
  chk_out_low: assert property (!oemr [*4] |-> qs == 6'h00)
    else $error("bank clock runs while disabled");
  chk_oe_same: assert property (oes == 6'h00 || oes == 6'h3F)
    else $error("drive enables disagree");
  chk_pair_eq: assert property (qs[5] == qs[4] && qs[3] == qs[2] && qs[1] == qs[0])
    else $error("bank pins differ");
  // Whole ticks only: no runt high or low level
  chk_high_min: assert property (disable iff (!rst_n_i || !oemr) $rose(qs[5]) |-> qs[5] [*2])
    else $error("short high pulse");
  chk_low_min: assert property (disable iff (!rst_n_i || !oemr) $fell(qs[1]) |-> !qs[1] [*2])
    else $error("short low pulse");
  // Bus answers after exactly one wait
  chk_one_wait: assert property (acc |=> pready_o)
    else $error("ready not after one wait");
  chk_ready_one: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  chk_bad_addr: assert property (acc && paddr_i != ADDR_W'(8'h00) && paddr_i != ADDR_W'(8'h04)
    |=> pslverr_o) else $error("unmapped access without error");
  cover property ($rose(qs[3]));
  cover property (!oemr);
  cover property (pready_o && pslverr_o);
endmodule : ckctl_top_props
bind ckctl_top ckctl_top_props #(.ADDR_W(ADDR_W)) u_props (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .output_enable_master_reset_i(output_enable_master_reset_i),
  .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o),
  .bank_a_outputs_o(bank_a_outputs_o), .bank_a_outputs_oe_o(bank_a_outputs_oe_o),
  .bank_b_outputs_o(bank_b_outputs_o), .bank_b_outputs_oe_o(bank_b_outputs_oe_o),
  .bank_c_outputs_o(bank_c_outputs_o), .bank_c_outputs_oe_o(bank_c_outputs_oe_o)
);
`default_nettype wire

// *** tb/ckctl_board_model.sv ***
// Board controller model: reference clocks, feedback and reset pulses
`timescale 1ns/10ps
`default_nettype none
module ckctl_board_model (
  input wire logic ref_clk_i,  // Clock
  input wire logic rst_n_i,  // Reset
  input wire logic xtal_run_i,  // Crystal runs
  input wire logic fb_run_i,  // Feedback runs
  input wire logic pulse_i,  // Start a reset pulse
  output logic xtal_o,  // Crystal reference
  output logic se_ref_o,  // Single-ended reference
  output logic fb_o,  // Feedback clock
  output logic oemr_o  // Enable pin
);
  logic [3:0] div_ff;
  logic [4:0] low_ff;
  // Reference of 16 clocks; reset pulse of 24 clocks outlasts one reference cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff <= 4'h0;
      low_ff <= 5'h00;
    end else begin
      div_ff <= div_ff + 4'h1;
      if (pulse_i) begin
        low_ff <= 5'h18;
      end else if (low_ff != 5'h00) begin
        low_ff <= low_ff - 5'h01;
      end
    end
  end
  // Stopped clocks rest low
  assign se_ref_o = div_ff[3];
  assign xtal_o = xtal_run_i & div_ff[3];
  assign fb_o = fb_run_i & div_ff[3];
  assign oemr_o = (low_ff == 5'h00);
endmodule : ckctl_board_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the clock output control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ckctl_pkg::*;
  typedef struct {logic [7:0] ctrl; int pa; int pb; int pc;} ckctl_row_t;
  ckctl_row_t rows [6] = '{'{8'h03, 4, 4, 8}, '{8'h00, 4, 0, 0}, '{8'h21, 4, 0, 12},
                           '{8'h06, 0, 0, 16}, '{8'h1B, 8, 8, 8}, '{8'h3F, 16, 16, 24}};
  logic ref_clk_i = 1'b0;
  logic rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, er;
  logic xtal, se_ref, fb, oemr, xtal_run, fb_run, pulse;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [3:0] pstrb_i;
  logic [1:0] qa, qb, qc, ea, eb, ec;
  int err_count = 0;
  int checks = 0;
  int p;
  ckctl_top dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .output_enable_master_reset_i(oemr),
    .crystal_reference_i(xtal), .single_ended_reference_input_i(se_ref),
    .external_feedback_input_i(fb), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .bank_a_outputs_o(qa), .bank_a_outputs_oe_o(ea), .bank_b_outputs_o(qb),
    .bank_b_outputs_oe_o(eb), .bank_c_outputs_o(qc), .bank_c_outputs_oe_o(ec));
  ckctl_board_model board (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .xtal_run_i(xtal_run),
    .fb_run_i(fb_run), .pulse_i(pulse), .xtal_o(xtal), .se_ref_o(se_ref), .fb_o(fb),
    .oemr_o(oemr));
  // Block clock, 8 ns period
  always #4 ref_clk_i = ~ref_clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One bus transfer; holds the request until ready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  function automatic logic qbit(input int b);
    return (b == 0) ? qa[0] : ((b == 1) ? qb[0] : qc[0]);
  endfunction : qbit
  // Clocks between the last two rising edges, else the resting level
  task automatic period(input int b, output int per);
    int r0;
    int r1;
    logic prev;
    logic cur;
    r0 = -1;
    r1 = -1;
    prev = qbit(b);
    cur = prev;
    for (int i = 0; i < 120; i++) begin
      @(posedge ref_clk_i);
      cur = qbit(b);
      if (cur && !prev) begin
        r0 = r1;
        r1 = i;
      end
      prev = cur;
    end
    per = (r0 >= 0) ? r1 - r0 : int'(cur);
  endtask : period
  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  // Watchdog well beyond the expected run
  initial begin
    #200000;
    err_count++;
    results();
  end
  initial begin
    {rst_n_i, psel_i, penable_i, pwrite_i, pulse, fb_run} = 6'h00;
    xtal_run = 1'b1;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    pstrb_i = 4'hF;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    foreach (rows[k]) begin
      apb(1'b1, 8'h00, {24'h0, rows[k].ctrl}, 4'hF);
      repeat (40) @(posedge ref_clk_i);
      apb(1'b0, 8'h00, 32'h0, 4'hF);
      check(rd, {24'h0, rows[k].ctrl});
      period(0, p);
      check(p, rows[k].pa);
      period(1, p);
      check(p, rows[k].pb);
      period(2, p);
      check(p, rows[k].pc);
      check({26'h0, ea, eb, ec}, 32'h3F);
      $display("row %0d done", k);
    end
    apb(1'b1, 8'h08, 32'h0, 4'hF);
    check({31'h0, er}, 32'h1);
    apb(1'b1, 8'h00, 32'h0, 4'hE);
    apb(1'b0, 8'h00, 32'h0, 4'hF);
    check(rd, 32'h3F);
    $display("refusals done");
    apb(1'b1, 8'h00, 32'h3, 4'hF);
    pulse <= 1'b1;
    @(posedge ref_clk_i);
    pulse <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    check({20'h0, ea, eb, ec, qa, qb, qc}, 32'h0);
    apb(1'b0, 8'h04, 32'h0, 4'hF);
    check({28'h0, rd[6:3]}, 32'h8);
    repeat (30) @(posedge ref_clk_i);
    check({26'h0, ea, eb, ec}, 32'h3F);
    $display("internal reset done");
    fb_run <= 1'b1;
    apb(1'b1, 8'h00, 32'hC3, 4'hF);
    repeat (100) @(posedge ref_clk_i);
    apb(1'b0, 8'h04, 32'h0, 4'hF);
    check({31'h0, rd[6]}, 32'h1);
    fb_run <= 1'b0;
    repeat (100) @(posedge ref_clk_i);
    apb(1'b0, 8'h04, 32'h0, 4'hF);
    check({31'h0, rd[6]}, 32'h0);
    pulse <= 1'b1;
    fb_run <= 1'b1;
    @(posedge ref_clk_i);
    pulse <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    apb(1'b0, 8'h04, 32'h0, 4'hF);
    check({30'h0, rd[5:4]}, 32'h3);
    repeat (60) @(posedge ref_clk_i);
    apb(1'b0, 8'h04, 32'h0, 4'hF);
    check({31'h0, rd[6]}, 32'h1);
    {xtal_run, fb_run} <= 2'b00;
    apb(1'b1, 8'h00, 32'h43, 4'hF);
    repeat (100) @(posedge ref_clk_i);
    apb(1'b0, 8'h04, 32'h0, 4'hF);
    check({31'h0, rd[6]}, 32'h1);
    apb(1'b1, 8'h00, 32'hC3, 4'hF);
    repeat (100) @(posedge ref_clk_i);
    apb(1'b0, 8'h04, 32'h0, 4'hF);
    check({31'h0, rd[6]}, 32'h0);
    $display("external feedback done");
    rst_n_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    check({26'h0, ea, eb, ec}, 32'h0);
    rst_n_i <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, 4'hF);
    check(rd, 32'h3);
    $display("reset done");
    results();
  end
endmodule : tb_top
`default_nettype wire
